// file: shared/sns_pkg.sv
`default_nettype none

package sns_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SNS_DATA_W  = 8;
  localparam int SNS_FADDR_W = 7;
  localparam int SNS_INSTR_W = 14;
  localparam int SNS_OPC_W   = 6;
  localparam int SNS_NIB_W   = 4;
  localparam int SNS_PADDR_W = 8;
  localparam int SNS_PDATA_W = 32;

  // ----------------------------------------------------------------
  // Instruction encodings (opcode is instruction bits 13:8)
  // ----------------------------------------------------------------
  localparam logic [SNS_OPC_W-1:0] SNS_OPC_SUBTRACT_W_FROM_REG = 6'h02;
  localparam logic [SNS_OPC_W-1:0] SNS_OPC_SWAP_NIBBLES        = 6'h0e;
  localparam logic                 SNS_DEST_ACC                = 1'b0;
  localparam logic                 SNS_DEST_REG                = 1'b1;

  // ----------------------------------------------------------------
  // APB register byte offsets
  // ----------------------------------------------------------------
  localparam logic [SNS_PADDR_W-1:0] SNS_OFF_INSTR  = 8'h00;
  localparam logic [SNS_PADDR_W-1:0] SNS_OFF_WACC   = 8'h04;
  localparam logic [SNS_PADDR_W-1:0] SNS_OFF_FLAGS  = 8'h08;
  localparam logic [SNS_PADDR_W-1:0] SNS_OFF_FADDR  = 8'h0c;
  localparam logic [SNS_PADDR_W-1:0] SNS_OFF_FDATA  = 8'h10;
  localparam logic [SNS_PADDR_W-1:0] SNS_OFF_RESULT = 8'h14;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SNS_DATA_W-1:0]  SNS_RST_BYTE  = 8'h00;
  localparam logic [SNS_INSTR_W-1:0] SNS_RST_INSTR = 14'h0000;
  localparam logic [SNS_PDATA_W-1:0] SNS_RST_WORD  = 32'h0000_0000;
  localparam logic [SNS_NIB_W-1:0]   SNS_ZERO_NIB  = 4'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SNS_OPC_W-1:0]   opcode;
    logic                   dest;
    logic [SNS_FADDR_W-1:0] faddr;
  } sns_instr_t;

  // Flags register layout: bit0 carry, bit1 digit carry, bit2 zero, bit3 illegal
  typedef struct packed {
    logic illegal;
    logic zero_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } sns_flags_t;

  localparam sns_flags_t SNS_RST_FLAGS = 4'h0;

  typedef enum logic [1:0] {
    SNS_IDLE,
    SNS_READ,
    SNS_EXEC,
    SNS_SETTLE
  } sns_state_t;

  // ----------------------------------------------------------------
  // a - b by two's complement; bit 8 is the no-borrow carry
  // ----------------------------------------------------------------
  function automatic logic [SNS_DATA_W:0] sns_sub9(
    input logic [SNS_DATA_W-1:0] a,
    input logic [SNS_DATA_W-1:0] b
  );
    sns_sub9 = {1'b0, a} + {1'b0, ~b} + {{SNS_DATA_W{1'b0}}, 1'b1};
  endfunction : sns_sub9

endpackage : sns_pkg

`default_nettype wire

// file: hw/sns_regfile.sv
`timescale 1ns/1ps
`default_nettype none

module sns_regfile #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
) (
  input  wire logic              clk,    // Core clock
  input  wire logic              rst_n,  // Async reset, read register only
  input  wire logic              we,     // Write enable
  input  wire logic [ADDR_W-1:0] waddr,  // Write address
  input  wire logic [DATA_W-1:0] wdata,  // Write data
  input  wire logic [ADDR_W-1:0] raddr,  // Read address
  output logic      [DATA_W-1:0] rdata   // Registered read data
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Array has no reset so it maps onto plain RAM
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Read-before-write: same-edge write shows one cycle later
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end

endmodule : sns_regfile

`default_nettype wire

// file: hw/sns_alu.sv
// Summary of operation
// RL1: Subtract opcode computes 8-bit register byte minus accumulator, two's complement.
// RL2: Subtract result goes to accumulator when dest is 0, else register.
// RL3: Register byte greater than accumulator sets carry and stores positive difference.
// RL4: Equal operands give zero result, carry set and zero flag set.
// RL5: Accumulator greater gives carry cleared and the wrapped 8-bit result.
// RL6: Swap opcode exchanges nibbles of register byte and changes no flag.
// RL7: Swap result goes to accumulator when dest 0, else to register.
// RL8: Digit carry set when low nibble subtraction needs no borrow, else cleared.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sns_alu #(
  parameter int FADDR_W = sns_pkg::SNS_FADDR_W
) (
  input  wire logic                             pclk,     // APB and core clock
  input  wire logic                             presetn,  // Async reset, active low
  input  wire logic                             psel,     // APB select
  input  wire logic                             penable,  // APB access phase
  input  wire logic                             pwrite,   // APB direction, 1 write
  input  wire logic [sns_pkg::SNS_PADDR_W-1:0]  paddr,    // APB byte address
  input  wire logic [sns_pkg::SNS_PDATA_W-1:0]  pwdata,   // APB write data
  output logic      [sns_pkg::SNS_PDATA_W-1:0]  prdata,   // APB read data
  output logic                                  pready,   // APB transfer done
  output logic                                  pslverr   // Unmapped address
);

  import sns_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Address field is fixed by the instruction word
  if (FADDR_W != SNS_FADDR_W)
  begin : g_bad_faddr
    $error("sns_alu: FADDR_W must match the instruction address field");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sns_state_t              state;
  sns_state_t              next_state;
  sns_instr_t              instr;
  sns_flags_t              flags;
  sns_flags_t              next_flags;
  logic [SNS_DATA_W-1:0]   wacc;
  logic [SNS_DATA_W-1:0]   result;
  logic [FADDR_W-1:0]      faddr;
  logic [SNS_DATA_W-1:0]   rd_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Register map, data in the low bits, upper bits read zero:
  // instruction, accumulator, flags, file address, file data window
  // and last result, which is read only and ignores writes
  // Writes land only on the edge that also samples pready high
  wire logic apb_access = psel & penable;
  wire logic apb_done   = apb_access & pready;
  wire logic apb_wr     = apb_done & pwrite;
  wire logic is_idle    = (state == SNS_IDLE);
  wire logic hit_instr  = (paddr == SNS_OFF_INSTR);
  wire logic hit_wacc   = (paddr == SNS_OFF_WACC);
  wire logic hit_flags  = (paddr == SNS_OFF_FLAGS);
  wire logic hit_faddr  = (paddr == SNS_OFF_FADDR);
  wire logic hit_fdata  = (paddr == SNS_OFF_FDATA);
  wire logic hit_result = (paddr == SNS_OFF_RESULT);
  wire logic mapped     = hit_instr | hit_wacc | hit_flags | hit_faddr
                          | hit_fdata | hit_result;

  // Write strobes, one per register; the result register takes none
  wire logic wr_instr   = apb_wr & hit_instr;
  wire logic wr_wacc    = apb_wr & hit_wacc;
  wire logic wr_flags   = apb_wr & hit_flags;
  wire logic wr_faddr   = apb_wr & hit_faddr;
  wire logic wr_fdata   = apb_wr & hit_fdata;

  // Read mux, narrow registers sit in the low bits
  wire logic [SNS_PDATA_W-1:0] rd_mux =
      hit_instr  ? SNS_PDATA_W'(instr)  :
      hit_wacc   ? SNS_PDATA_W'(wacc)   :
      hit_flags  ? SNS_PDATA_W'(flags)  :
      hit_faddr  ? SNS_PDATA_W'(faddr)  :
      hit_fdata  ? SNS_PDATA_W'(rd_q)   :
      hit_result ? SNS_PDATA_W'(result) : SNS_RST_WORD;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // Two opcodes are served; any other only raises the illegal flag
  wire logic is_sub   = (instr.opcode == SNS_OPC_SUBTRACT_W_FROM_REG);
  wire logic is_swap  = (instr.opcode == SNS_OPC_SWAP_NIBBLES);
  wire logic legal    = is_sub | is_swap;
  wire logic in_exec  = (state == SNS_EXEC);
  wire logic to_reg   = in_exec & legal & (instr.dest == SNS_DEST_REG);  // RL2 RL7
  wire logic to_acc   = in_exec & legal & (instr.dest == SNS_DEST_ACC);  // RL2 RL7

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  // Full byte and low nibble share one subtractor function
  wire logic [SNS_DATA_W:0] sub_byte = sns_sub9(rd_q, wacc);  // RL1
  wire logic [SNS_DATA_W:0] sub_nib  =
      sns_sub9({SNS_ZERO_NIB, rd_q[SNS_NIB_W-1:0]},
               {SNS_ZERO_NIB, wacc[SNS_NIB_W-1:0]});          // RL8
  // Swap is wiring only and never reaches the flags
  wire logic [SNS_DATA_W-1:0] swapped =
      {rd_q[SNS_NIB_W-1:0], rd_q[SNS_DATA_W-1:SNS_NIB_W]};    // RL6
  // Result mux, chosen by the opcode
  wire logic [SNS_DATA_W-1:0] exec_result =
      is_sub ? sub_byte[SNS_DATA_W-1:0] : swapped;            // RL3 RL5
  // Zero test sees the byte that is actually stored
  wire logic exec_zero = (exec_result == SNS_RST_BYTE);

  // Flags: only subtraction and illegal opcodes touch them; hardware wins over software
  always_comb
  begin
    next_flags = flags;
    if (wr_flags)
    begin
      next_flags = sns_flags_t'(pwdata[$bits(sns_flags_t)-1:0]);
    end
    if (in_exec && is_sub)
    begin
      next_flags.carry_flag       = sub_byte[SNS_DATA_W];  // RL3 RL4 RL5
      next_flags.digit_carry_flag = sub_nib[SNS_DATA_W];   // RL8
      next_flags.zero_flag        = exec_zero;             // RL4
    end
    // Sticky until software writes the flags register
    if (in_exec && !legal)
    begin
      next_flags.illegal = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // IDLE waits for a software write of the instruction word.
  // READ fetches the register byte at the instruction's address.
  // EXEC writes result, accumulator or register byte, and flags on a subtraction.
  // SETTLE lets a byte written back reach the read register again.
  // Illegal opcodes walk the same path but change no data.
  // APB is held off outside IDLE, so software never races the core.
  // Three stall cycles per instruction buy a simple one-port file.
  always_comb
  begin
    case (state)
      SNS_IDLE:   next_state = wr_instr ? SNS_READ : SNS_IDLE;
      SNS_READ:   next_state = SNS_EXEC;
      SNS_EXEC:   next_state = SNS_SETTLE;
      SNS_SETTLE: next_state = SNS_IDLE;
      default:    next_state = SNS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= SNS_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------
  // Instruction word; writing it launches the sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr <= sns_instr_t'(SNS_RST_INSTR);
    end
    else if (wr_instr)
    begin
      instr <= sns_instr_t'(pwdata[SNS_INSTR_W-1:0]);
    end
  end

  // Window address for software access to the register file
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      faddr <= '0;
    end
    else if (wr_faddr)
    begin
      faddr <= pwdata[FADDR_W-1:0];
    end
  end

  // Flags follow the merged software and hardware update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags <= SNS_RST_FLAGS;
    end
    else
    begin
      flags <= next_flags;
    end
  end

  // Accumulator kept unless dest selects it; the sequencer wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wacc <= SNS_RST_BYTE;
    end
    else if (to_acc)
    begin
      wacc <= exec_result;  // RL2 RL7
    end
    else if (wr_wacc)
    begin
      wacc <= pwdata[SNS_DATA_W-1:0];
    end
  end

  // Last result of a legal instruction, read only to software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result <= SNS_RST_BYTE;
    end
    else if (in_exec && legal)
    begin
      result <= exec_result;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Software and the sequencer never write in the same cycle
  wire logic               rf_we    = to_reg | wr_fdata;
  wire logic [FADDR_W-1:0] rf_waddr = to_reg ? instr.faddr : faddr;
  wire logic [SNS_DATA_W-1:0] rf_wdata =
      to_reg ? exec_result : pwdata[SNS_DATA_W-1:0];             // RL2 RL7
  // Sequencer borrows the read port only in READ
  wire logic [FADDR_W-1:0] rf_raddr =
      (state == SNS_READ) ? instr.faddr : faddr;

  // Registered read port; the array itself has no reset
  sns_regfile #(
    .DATA_W (SNS_DATA_W),
    .ADDR_W (FADDR_W)
  ) u_regfile (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (rf_we),
    .waddr (rf_waddr),
    .wdata (rf_wdata),
    .raddr (rf_raddr),
    .rdata (rd_q)
  );

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // First access cycle while idle; a running instruction holds it off
  wire logic apb_start = apb_access & ~pready & is_idle;

  // One wait state: pready rises for one cycle, with pslverr alongside it only for an unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_start;
      pslverr <= apb_start & ~mapped;
    end
  end

  // Read data caught at the start and held until the next read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= SNS_RST_WORD;
    end
    else if (apb_start && !pwrite)
    begin
      prdata <= rd_mux;
    end
  end

endmodule : sns_alu

`default_nettype wire

// file: verification/sns_alu_sva.sv
`timescale 1ns/1ps
`default_nettype none

module sns_alu_sva
  import sns_pkg::*;
#(
  parameter int FADDR_W = sns_pkg::SNS_FADDR_W
) (
  input wire logic                            pclk,     // Clock
  input wire logic                            presetn,  // Async reset, active low
  input wire logic                            psel,     // APB select
  input wire logic                            penable,  // APB access phase
  input wire logic                            pwrite,   // APB direction
  input wire logic [sns_pkg::SNS_PADDR_W-1:0] paddr,    // APB byte address
  input wire logic [sns_pkg::SNS_PDATA_W-1:0] pwdata,   // APB write data
  input wire logic [sns_pkg::SNS_PDATA_W-1:0] prdata,   // APB read data
  input wire logic                            pready,   // APB transfer done
  input wire logic                            pslverr   // APB error
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Only the six exact word offsets answer without error
  wire logic mapped;
  wire logic byte_reg;
  assign mapped = (paddr == SNS_OFF_INSTR) || (paddr == SNS_OFF_WACC) ||
                  (paddr == SNS_OFF_FLAGS) || (paddr == SNS_OFF_FADDR) ||
                  (paddr == SNS_OFF_FDATA) || (paddr == SNS_OFF_RESULT);
  assign byte_reg = (paddr == SNS_OFF_WACC) || (paddr == SNS_OFF_FDATA) ||
                    (paddr == SNS_OFF_RESULT);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // First access cycle of a transfer
  sequence acc_first;
    psel && penable && $rose(penable);
  endsequence
  sequence read_done;
    pready && !pwrite;
  endsequence

  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  wait_state_a: assert property (acc_first |-> !pready)
    else $error("pready without the wait state");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  decode_err_a: assert property (pready |-> (pslverr == !mapped))
    else $error("pslverr does not match the address decode");
  err_data_zero_a: assert property (read_done and pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  prdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("prdata moved outside a read");
  byte_width_a: assert property (read_done and byte_reg |-> prdata[31:8] == 24'h00_0000)
    else $error("byte register read has upper bits set");
  flags_width_a: assert property (read_done and paddr == SNS_OFF_FLAGS |-> prdata[31:4] == 28'h0)
    else $error("flags read has upper bits set");
endmodule : sns_alu_sva

bind sns_alu sns_alu_sva #(.FADDR_W(FADDR_W)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

`default_nettype wire

// file: verification/sns_apb_master.sv
`timescale 1ns/1ps
`default_nettype none

module sns_apb_master
  import sns_pkg::*;
(
  input  wire logic                            pclk,     // Clock
  input  wire logic [sns_pkg::SNS_PDATA_W-1:0] prdata,   // Read data from block
  input  wire logic                            pready,   // Transfer done
  input  wire logic                            pslverr,  // Transfer refused
  output logic                                 psel,     // APB select
  output logic                                 penable,  // APB access phase
  output logic                                 pwrite,   // APB direction
  output logic      [sns_pkg::SNS_PADDR_W-1:0] paddr,    // APB byte address
  output logic      [sns_pkg::SNS_PDATA_W-1:0] pwdata    // APB write data
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // One transfer
  // ----------------------------------------------------------------
  // Waits on pready with no cycle count; the bench timeout ends a hang.
  // Released address and write data are inverted so stale values never look valid.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask : xfer
endmodule : sns_apb_master

`default_nettype wire

// file: verification/sns_alu_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sns_alu_bench;
  import sns_pkg::*;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          bad_count = 0;
  int          checked = 0;
  int          cycles = 0;

  always #25 pclk = ~pclk;

  sns_alu dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  sns_apb_master mst_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    mst_u.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    mst_u.xfer(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(SNS_OFF_WACC, 32'h0);
    rd(SNS_OFF_FLAGS, 32'h0);
    rd(SNS_OFF_INSTR, 32'h0);
    rd(SNS_OFF_RESULT, 32'h0);
  endtask : t_reset

  // Positive, zero, wrapped and nibble-borrow cases, both destinations
  task automatic t_sub();
    logic [7:0] f [5] = '{8'h03, 8'h02, 8'h01, 8'h10, 8'h0f};
    logic [7:0] w [5] = '{8'h02, 8'h02, 8'h02, 8'h01, 8'h01};
    logic       d [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] r;
    logic [6:0] a;
    logic [3:0] fl;
    for (int i = 0; i < 5; i++)
    begin
      a = 7'h7f - 7'(i);
      r = f[i] - w[i];
      fl = {1'b0, r == 8'h00, f[i][3:0] >= w[i][3:0], f[i] >= w[i]};
      wr(SNS_OFF_FADDR, {25'h0, a});
      wr(SNS_OFF_FDATA, {24'h0, f[i]});
      wr(SNS_OFF_WACC, {24'h0, w[i]});
      wr(SNS_OFF_FLAGS, {29'h0, ~fl[2:0]});
      wr(SNS_OFF_INSTR, {18'h0, SNS_OPC_SUBTRACT_W_FROM_REG, d[i], a});
      rd(SNS_OFF_WACC, {24'h0, d[i] ? w[i] : r});
      rd(SNS_OFF_FDATA, {24'h0, d[i] ? r : f[i]});
      rd(SNS_OFF_FLAGS, {28'h0, fl});
      rd(SNS_OFF_RESULT, {24'h0, r});
    end
  endtask : t_sub

  task automatic t_swap();
    wr(SNS_OFF_FADDR, 32'h5);
    wr(SNS_OFF_FDATA, 32'ha5);
    wr(SNS_OFF_WACC, 32'h33);
    wr(SNS_OFF_FLAGS, 32'h5);
    wr(SNS_OFF_INSTR, {18'h0, SNS_OPC_SWAP_NIBBLES, SNS_DEST_ACC, 7'h05});
    rd(SNS_OFF_WACC, 32'h5a);
    rd(SNS_OFF_FDATA, 32'ha5);
    rd(SNS_OFF_FLAGS, 32'h5);
    wr(SNS_OFF_WACC, 32'h33);
    wr(SNS_OFF_INSTR, {18'h0, SNS_OPC_SWAP_NIBBLES, SNS_DEST_REG, 7'h05});
    rd(SNS_OFF_FDATA, 32'h5a);
    rd(SNS_OFF_WACC, 32'h33);
    rd(SNS_OFF_FLAGS, 32'h5);
  endtask : t_swap

  // Unmapped and misaligned places, read-only result, unknown opcode
  task automatic t_refuse();
    logic [31:0] r;
    logic        e;
    mst_u.xfer(1'b1, 8'h18, 32'hff, r, e);
    check({31'h0, e}, 32'h1);
    mst_u.xfer(1'b0, 8'h03, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    wr(SNS_OFF_RESULT, 32'hff);
    rd(SNS_OFF_RESULT, 32'h5a);
    wr(SNS_OFF_INSTR, {18'h0, 6'h3f, 8'h05});
    rd(SNS_OFF_FLAGS, 32'hd);
    rd(SNS_OFF_FDATA, 32'h5a);
  endtask : t_refuse

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sub();
    t_swap();
    t_refuse();
    end_sim();
  end

  // Whole run needs well under a thousand cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      end_sim();
    end
  end
endmodule : sns_alu_bench

`default_nettype wire
